// *** rtl/phy_bmc_consts.svh ***
`ifndef PHY_BMC_CONSTS_SVH
`define PHY_BMC_CONSTS_SVH

`define BMC_ADDR 5'h00
`define EVT_ADDR 5'h1e

`define BMC_RESET 15
`define BMC_LOOP 14
`define BMC_SPEED 13
`define BMC_ANEN 12
`define BMC_PDOWN 11
`define BMC_ISO 10
`define BMC_RESTART 9
`define BMC_DUPLEX 8
`define BMC_COLTEST 7

`define SPEED_RST 1'h1
`define DUPLEX_RST 1'h0

`define PRE_ONES 6'h20
`define OP_RD 2'h2
`define OP_WR 2'h1
`define LAST_OP 6'h01
`define LAST_ADR 6'h09
`define LAST_DATA 6'h0f

`define SRST_CYCLES 8'h20
`define CLK_NS 25
`define DEAD_US 500

`endif

// *** rtl/phy_bmc_pkg.sv ***
package phy_bmc_pkg;

  typedef enum logic [2:0] {
    MG_PRE = 3'h0,
    MG_START = 3'h1,
    MG_OP = 3'h3,
    MG_ADR = 3'h2,
    MG_TURN = 3'h6,
    MG_DATA = 3'h7
  } mgmt_state_e;

  typedef logic [15:0] mgmt_word_t;

endpackage

// *** rtl/phy_basic_mode_control.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "phy_bmc_consts.svh"

module phy_basic_mode_control #(
  parameter int DEAD_CYCLES = `DEAD_US * 1000 / `CLK_NS,
  parameter logic [11:0] FIXED_VAL = 12'h000
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] strap_phy_addr,
  input wire logic strap_an_en,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  output logic [3:0] rxd,
  output logic rx_dv,
  output logic crs,
  output logic col,
  output logic mii_oe,
  input wire logic [3:0] core_rxd,
  input wire logic core_rx_dv,
  input wire logic core_crs,
  input wire logic core_col,
  output logic [3:0] core_txd,
  output logic core_tx_en,
  input wire logic an_started,
  input wire logic an_speed_100,
  input wire logic an_full_duplex,
  input wire logic [3:0] evt_in,
  output logic soft_reset,
  output logic an_enable,
  output logic an_restart,
  output logic speed_100,
  output logic full_duplex,
  output logic power_down,
  output logic isolate,
  output logic loopback
);

  localparam int SW = 13;
  localparam int DW = $clog2(DEAD_CYCLES + 1);

  function automatic logic [15:0] sel_word(
    input logic [4:0] a,
    input logic [15:0] w_bmc,
    input logic [15:0] w_evt
  );
    logic [15:0] w;
    w = 16'h0000;
    if (a == `BMC_ADDR) begin
      w = w_bmc;
    end else if (a == `EVT_ADDR) begin
      w = w_evt;
    end
    return w;
  endfunction

  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  logic [SW-1:0] in_raw;
  logic mdc_s;
  logic mdio_s;
  logic tx_en_s;
  logic [3:0] txd_s;
  logic strap_an_s;
  logic [4:0] strap_adr_s;
  logic mdc_q_r;
  logic mdc_rise;

  phy_bmc_pkg::mgmt_state_e state_r;
  logic [5:0] cnt_r;
  logic [1:0] op_r;
  logic [9:0] adr_r;
  logic [15:0] sh_r;
  logic match;
  logic rd_hit;
  logic rd_go;
  logic wr_go;
  logic [15:0] wr_data;
  logic [15:0] rd_word;
  logic wr_bmc;
  logic rd_evt;

  logic rst_busy_r;
  logic [7:0] rst_cnt_r;
  logic [4:0] phy_adr_r;
  logic loop_r;
  logic speed_r;
  logic an_en_r;
  logic pdown_r;
  logic iso_r;
  logic restart_r;
  logic duplex_r;
  logic coltest_r;
  phy_bmc_pkg::mgmt_word_t bmc_word;

  logic lh_r;
  logic ll_r;
  logic cor_r;
  logic [15:0] evt_word;

  logic lb_q_r;
  logic [DW-1:0] dead_cnt_r;
  logic quiet;

  assign in_raw = {mdc, mdio_in, tx_en, txd, strap_an_en, strap_phy_addr};

  // Pin synchronisers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= in_raw;
      sync2_r <= sync1_r;
    end
  end

  assign mdc_s = sync2_r[12];
  assign mdio_s = sync2_r[11];
  assign tx_en_s = sync2_r[10];
  assign txd_s = sync2_r[9:6];
  assign strap_an_s = sync2_r[5];
  assign strap_adr_s = sync2_r[4:0];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mdc_q_r <= 1'h0;
    end else begin
      mdc_q_r <= mdc_s;
    end
  end

  assign mdc_rise = mdc_s & ~mdc_q_r;

  assign match = (adr_r[9:5] == phy_adr_r);
  assign rd_hit = match && (op_r == `OP_RD);
  assign rd_go = mdc_rise && rd_hit && (state_r == phy_bmc_pkg::MG_TURN) && (cnt_r == 6'h00);
  assign wr_go = mdc_rise && match && (op_r == `OP_WR) && (state_r == phy_bmc_pkg::MG_DATA)
                 && (cnt_r == `LAST_DATA);
  assign wr_data = {sh_r[14:0], mdio_s};
  assign rd_word = sel_word(adr_r[4:0], bmc_word, evt_word);
  assign wr_bmc = wr_go && (adr_r[4:0] == `BMC_ADDR);
  assign rd_evt = rd_go && (adr_r[4:0] == `EVT_ADDR);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= phy_bmc_pkg::MG_PRE;
      cnt_r <= 6'h00;
      op_r <= 2'h0;
      adr_r <= 10'h000;
      sh_r <= 16'h0000;
      mdio_out <= 1'h0;
      mdio_oe <= 1'h0;
    end else if (mdc_rise) begin
      case (state_r)
        phy_bmc_pkg::MG_PRE: begin
          if (mdio_s) begin
            if (cnt_r != `PRE_ONES) begin
              cnt_r <= cnt_r + 6'h01;
            end
          end else begin
            if (cnt_r == `PRE_ONES) begin
              state_r <= phy_bmc_pkg::MG_START;
            end
            cnt_r <= 6'h00;
          end
        end
        phy_bmc_pkg::MG_START: begin
          state_r <= mdio_s ? phy_bmc_pkg::MG_OP : phy_bmc_pkg::MG_PRE;
          cnt_r <= 6'h00;
        end
        phy_bmc_pkg::MG_OP: begin
          op_r <= {op_r[0], mdio_s};
          if (cnt_r == `LAST_OP) begin
            state_r <= phy_bmc_pkg::MG_ADR;
            cnt_r <= 6'h00;
          end else begin
            cnt_r <= cnt_r + 6'h01;
          end
        end
        phy_bmc_pkg::MG_ADR: begin
          adr_r <= {adr_r[8:0], mdio_s};
          if (cnt_r == `LAST_ADR) begin
            state_r <= phy_bmc_pkg::MG_TURN;
            cnt_r <= 6'h00;
          end else begin
            cnt_r <= cnt_r + 6'h01;
          end
        end
        phy_bmc_pkg::MG_TURN: begin
          if (cnt_r == 6'h00) begin
            cnt_r <= 6'h01;
            sh_r <= rd_word;
            if (rd_hit) begin
              mdio_oe <= 1'h1;
              mdio_out <= 1'h0;
            end
          end else begin
            state_r <= phy_bmc_pkg::MG_DATA;
            cnt_r <= 6'h00;
            mdio_out <= rd_hit & sh_r[15];
            sh_r <= {sh_r[14:0], 1'h0};
          end
        end
        phy_bmc_pkg::MG_DATA: begin
          sh_r <= {sh_r[14:0], mdio_s};
          if (cnt_r == `LAST_DATA) begin
            state_r <= phy_bmc_pkg::MG_PRE;
            cnt_r <= 6'h00;
            mdio_oe <= 1'h0;
            mdio_out <= 1'h0;
          end else begin
            cnt_r <= cnt_r + 6'h01;
            mdio_out <= mdio_oe & sh_r[15];
          end
        end
        default: begin
          state_r <= phy_bmc_pkg::MG_PRE;
          cnt_r <= 6'h00;
          mdio_oe <= 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rst_busy_r <= 1'h1;
      rst_cnt_r <= `SRST_CYCLES;
      phy_adr_r <= 5'h00;
      an_en_r <= 1'h0;
    end else if (rst_busy_r) begin
      if (rst_cnt_r == 8'h00) begin
        rst_busy_r <= 1'h0;
        phy_adr_r <= strap_adr_s;
        an_en_r <= strap_an_s;
      end else begin
        rst_cnt_r <= rst_cnt_r - 8'h01;
      end
    end else if (wr_bmc) begin
      if (wr_data[`BMC_RESET]) begin
        rst_busy_r <= 1'h1;
        rst_cnt_r <= `SRST_CYCLES;
      end else begin
        an_en_r <= wr_data[`BMC_ANEN];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || rst_busy_r || (wr_bmc && wr_data[`BMC_RESET])) begin
      loop_r <= 1'h0;
      speed_r <= `SPEED_RST;
      pdown_r <= 1'h0;
      iso_r <= 1'h0;
      duplex_r <= `DUPLEX_RST;
      coltest_r <= 1'h0;
    end else if (wr_bmc) begin
      loop_r <= wr_data[`BMC_LOOP];
      speed_r <= wr_data[`BMC_SPEED];
      pdown_r <= wr_data[`BMC_PDOWN];
      iso_r <= wr_data[`BMC_ISO];
      duplex_r <= wr_data[`BMC_DUPLEX];
      coltest_r <= wr_data[`BMC_COLTEST];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || rst_busy_r || (wr_bmc && wr_data[`BMC_RESET])) begin
      restart_r <= 1'h0;
    end else if (wr_bmc && wr_data[`BMC_RESTART] && wr_data[`BMC_ANEN]) begin
      restart_r <= 1'h1;
    end else if (an_started) begin
      restart_r <= 1'h0;
    end
  end

  always_comb begin
    bmc_word = 16'h0000;
    bmc_word[`BMC_RESET] = rst_busy_r;
    bmc_word[`BMC_LOOP] = loop_r;
    bmc_word[`BMC_SPEED] = speed_r;
    bmc_word[`BMC_ANEN] = an_en_r;
    bmc_word[`BMC_PDOWN] = pdown_r;
    bmc_word[`BMC_ISO] = iso_r;
    bmc_word[`BMC_RESTART] = restart_r;
    bmc_word[`BMC_DUPLEX] = duplex_r;
    bmc_word[`BMC_COLTEST] = coltest_r;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lh_r <= 1'h0;
    end else if (evt_in[1]) begin
      lh_r <= 1'h1;
    end else if (rd_evt) begin
      lh_r <= 1'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ll_r <= 1'h1;
    end else if (!evt_in[2]) begin
      ll_r <= 1'h0;
    end else if (rd_evt) begin
      ll_r <= 1'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cor_r <= 1'h0;
    end else if (evt_in[3]) begin
      cor_r <= 1'h1;
    end else if (rd_evt) begin
      cor_r <= 1'h0;
    end
  end

  assign evt_word = {FIXED_VAL, cor_r, ll_r, lh_r, evt_in[0]};

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lb_q_r <= 1'h0;
      dead_cnt_r <= '0;
    end else begin
      lb_q_r <= loop_r;
      if (loop_r && !lb_q_r) begin
        dead_cnt_r <= DW'(DEAD_CYCLES);
      end else if (dead_cnt_r != '0) begin
        dead_cnt_r <= dead_cnt_r - DW'(1);
      end
    end
  end

  assign quiet = pdown_r | iso_r | rst_busy_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst || quiet) begin
      rxd <= 4'h0;
      rx_dv <= 1'h0;
      crs <= 1'h0;
      col <= 1'h0;
    end else if (loop_r) begin
      rxd <= txd_s;
      rx_dv <= tx_en_s && lb_q_r && (dead_cnt_r == '0);
      crs <= tx_en_s;
      col <= coltest_r & tx_en_s;
    end else begin
      rxd <= core_rxd;
      rx_dv <= core_rx_dv;
      crs <= core_crs;
      col <= core_col | (coltest_r & tx_en_s);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || quiet || loop_r) begin
      core_txd <= 4'h0;
      core_tx_en <= 1'h0;
    end else begin
      core_txd <= txd_s;
      core_tx_en <= tx_en_s;
    end
  end

  assign mii_oe = ~iso_r;
  assign soft_reset = rst_busy_r;
  assign an_enable = an_en_r;
  assign an_restart = restart_r;
  assign speed_100 = an_en_r ? an_speed_100 : speed_r;
  assign full_duplex = an_en_r ? an_full_duplex : duplex_r;
  assign power_down = pdown_r;
  assign isolate = iso_r;
  assign loopback = loop_r;

endmodule

`default_nettype wire

// *** tb/phy_bmc_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module phy_bmc_props (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic loopback,
  input wire logic rx_dv,
  input wire logic [3:0] rxd,
  input wire logic crs,
  input wire logic col,
  input wire logic tx_en,
  input wire logic core_col,
  input wire logic an_enable,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic an_speed_100,
  input wire logic an_full_duplex,
  input wire logic mii_oe,
  input wire logic isolate,
  input wire logic power_down,
  input wire logic core_tx_en,
  input wire logic soft_reset,
  input wire logic an_restart,
  input wire logic an_started
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_LOOP_DEAD: assert property ($rose(loopback) |=> !rx_dv [*8])
    else $error("rx_dv in dead time");
  AST_COL_FALL: assert property ($fell(tx_en) && !core_col && !loopback |-> ##[1:4] !col)
    else $error("col late to drop");
  AST_AN_SEL: assert property (an_enable |-> speed_100 == an_speed_100 && full_duplex == an_full_duplex)
    else $error("forced mode used under negotiation");
  AST_MII_REL: assert property (isolate |-> !mii_oe ##1 !core_tx_en)
    else $error("MAC side not released while isolated");
  AST_ISO_QUIET: assert property (isolate && $past(isolate) |-> !rx_dv && !crs && !col && rxd == 4'h0)
    else $error("MAC outputs active while isolated");
  AST_PD_TX: assert property (power_down && $past(power_down) |-> !core_tx_en)
    else $error("transmit while powered down");
  AST_SRST_END: assert property ($rose(soft_reset) |-> ##[1:40] !soft_reset)
    else $error("soft reset stuck");
  AST_RST_HOLD: assert property (an_restart && !an_started |=> an_restart || soft_reset)
    else $error("restart lost before start");
  AST_RST_EN: assert property ($rose(an_restart) |-> an_enable)
    else $error("restart without negotiation");
endmodule
bind phy_basic_mode_control phy_bmc_props u_props (.core_clk, .sys_rst, .loopback, .rx_dv, .rxd, .crs,
  .col, .tx_en, .core_col, .an_enable, .speed_100, .full_duplex, .an_speed_100, .an_full_duplex,
  .mii_oe, .isolate, .power_down, .core_tx_en, .soft_reset, .an_restart, .an_started);
`default_nettype wire

// *** tb/mgmt_master.sv ***
`timescale 1ns/100ps
`default_nettype none
module mgmt_master (
  output logic mdc,
  output logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe
);
  logic drv = 1'b0;
  logic bit_v = 1'b1;
  // Pull-up when released
  assign mdio_in = mdio_oe ? mdio_out : (drv ? bit_v : 1'b1);
  initial mdc = 1'b0;
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
    input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] fr;
    fr = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      drv = (op == 2'b01) || (i < 46);
      bit_v = fr[63 - i];
      #100 mdc = 1'b1;
      if (i > 47) rd[63 - i] = mdio_in;
      #100 mdc = 1'b0;
    end
    drv = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic mdc, mdio_in, mdio_out, mdio_oe;
  logic strap_an_en = 1'b1;
  logic tx_en = 1'b0;
  logic [3:0] txd = 4'h0;
  logic an_started = 1'b0;
  logic an_speed_100 = 1'b1;
  logic an_full_duplex = 1'b0;
  logic [3:0] evt_in = 4'h4;
  logic [3:0] core_rxd = 4'h0;
  logic core_rx_dv = 1'b0;
  logic core_crs = 1'b0;
  logic core_col = 1'b0;
  logic [3:0] rxd, core_txd;
  logic rx_dv, crs, col, mii_oe, core_tx_en, soft_reset, an_enable, an_restart;
  logic speed_100, full_duplex, power_down, isolate, loopback;
  logic [15:0] rv;
  int mismatches = 0;
  int total_checks = 0;
  always #12.5 core_clk = ~core_clk;
  phy_basic_mode_control #(.DEAD_CYCLES(20), .FIXED_VAL(12'h5a3)) uut (
    .core_clk(core_clk), .sys_rst(sys_rst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .strap_phy_addr(5'h05), .strap_an_en(strap_an_en), .tx_en(tx_en), .txd(txd),
    .rxd(rxd), .rx_dv(rx_dv), .crs(crs), .col(col), .mii_oe(mii_oe), .core_rxd(core_rxd),
    .core_rx_dv(core_rx_dv), .core_crs(core_crs), .core_col(core_col), .core_txd(core_txd),
    .core_tx_en(core_tx_en),
    .an_started(an_started), .an_speed_100(an_speed_100), .an_full_duplex(an_full_duplex),
    .evt_in(evt_in), .soft_reset(soft_reset), .an_enable(an_enable), .an_restart(an_restart),
    .speed_100(speed_100), .full_duplex(full_duplex), .power_down(power_down), .isolate(isolate),
    .loopback(loopback));
  mgmt_master mm (.mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    mm.xfer(2'b01, 5'h05, ra, d, rv);
    repeat (4) @(negedge core_clk);
  endtask
  task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
    mm.xfer(2'b10, 5'h05, ra, 16'h0000, rv);
    chk(rv, exp);
  endtask
  task automatic t_reset;
    rd(5'h00, 16'h3000);
    rd(5'h03, 16'h0000);
    mm.xfer(2'b10, 5'h06, 5'h00, 16'h0000, rv);
    chk(rv, 16'hffff);
  endtask
  task automatic t_force;
    wr(5'h00, 16'h217f);
    rd(5'h00, 16'h2100);
    chk(16'({speed_100, full_duplex}), 16'h0003);
    wr(5'h00, 16'h0000);
    chk(16'({speed_100, full_duplex}), 16'h0000);
    wr(5'h00, 16'h1100);
    chk(16'({speed_100, full_duplex}), 16'h0002);
  endtask
  task automatic t_restart;
    wr(5'h00, 16'h1200);
    rd(5'h00, 16'h1200);
    wr(5'h00, 16'h1000);
    chk(16'(an_restart), 16'h0001);
    @(negedge core_clk) an_started = 1'b1;
    @(negedge core_clk) an_started = 1'b0;
    rd(5'h00, 16'h1000);
    wr(5'h00, 16'h0200);
    rd(5'h00, 16'h0000);
  endtask
  task automatic t_modes;
    wr(5'h00, 16'h4c80);
    chk(16'({loopback, power_down, isolate, mii_oe}), 16'h000e);
    rd(5'h00, 16'h4c80);
    wr(5'h00, 16'h0080);
    txd = 4'h5;
    core_rxd = 4'h6;
    core_rx_dv = 1'b1;
    core_crs = 1'b1;
    tx_en = 1'b1;
    repeat (8) @(negedge core_clk);
    chk(16'(col), 16'h0001);
    chk(16'({core_tx_en, core_txd}), 16'h0015);
    chk(16'({crs, rx_dv, rxd}), 16'h0036);
    tx_en = 1'b0;
    repeat (4) @(negedge core_clk);
    chk(16'(col), 16'h0000);
    core_col = 1'b1;
    repeat (2) @(negedge core_clk);
    chk(16'(col), 16'h0001);
    core_col = 1'b0;
    txd = 4'ha;
    tx_en = 1'b1;
    wr(5'h00, 16'h4000);
    chk(16'(rx_dv), 16'h0000);
    repeat (30) @(negedge core_clk);
    chk(16'({rx_dv, rxd}), 16'h001a);
    chk(16'(core_tx_en), 16'h0000);
    tx_en = 1'b0;
  endtask
  task automatic t_events;
    mm.xfer(2'b10, 5'h05, 5'h1e, 16'h0000, rv);
    @(negedge core_clk) evt_in = 4'hb;
    repeat (2) @(negedge core_clk);
    evt_in = 4'h5;
    rd(5'h1e, 16'h5a3b);
    rd(5'h1e, 16'h5a35);
    @(negedge core_clk) evt_in = 4'h4;
    wr(5'h1e, 16'hffff);
    rd(5'h1e, 16'h5a34);
  endtask
  task automatic t_srst;
    @(negedge core_clk) strap_an_en = 1'b0;
    mm.xfer(2'b01, 5'h05, 5'h00, 16'h8000, rv);
    chk(16'(soft_reset), 16'h0001);
    repeat (60) @(negedge core_clk);
    rd(5'h00, 16'h2000);
  endtask
  task automatic end_sim;
    if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (40) @(negedge core_clk);
    t_reset;
    t_force;
    t_restart;
    t_modes;
    t_events;
    t_srst;
    end_sim;
  end
  initial begin
    #2000000;
    mismatches++;
    end_sim;
  end
endmodule
`default_nettype wire
